// ==== logic/p1gpio_pkg.sv ====
package p1gpio_pkg;
  // word offsets (byte addresses) on the register bus
  localparam logic [3:0] OFS_FSEL = 4'h0;
  localparam logic [3:0] OFS_DIR  = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_PULL = 4'hc;

  localparam int NPIN = 8;

  // select bit positions
  localparam int SEL_INT3  = 7;
  localparam int SEL_INT2  = 6;
  localparam int SEL_INT1  = 5;
  localparam int SEL_INT0  = 4;
  localparam int SEL_TX2   = 3;
  localparam int SEL_PWM   = 2;
  localparam int SEL_TX1   = 1;
  localparam int SEL_RTC   = 0;
  localparam int EMPTY_BIT = 3;
  // pins that carry the alternate outputs
  localparam int PIN_PWM   = 1;
  localparam int PIN_RTC   = 0;

  localparam logic [7:0] FSEL_RST  = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h08;
  localparam logic [7:0] PULL_RST  = 8'h08;
  // bit with no pin behind it
  localparam logic [7:0] EMPTY_MSK = 8'h08;
  // pins that take an alternate input (4..7)
  localparam logic [7:0] ALT_IN_MSK  = 8'hf0;
  // pins that take an alternate output (0 and 1)
  localparam logic [7:0] ALT_OUT_MSK = 8'h03;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [7:0] writedata;
  } p1g_req_t;

  typedef struct packed {
    logic ext_int_3;
    logic ext_int_2;
    logic ext_int_1;
    logic ext_int_0;
    logic timer_v_trigger_in;
    logic timer_b1_event_in;
  } p1g_alt_in_t;
endpackage : p1gpio_pkg

// ==== logic/p1gpio_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // first stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : p1gpio_sync
`default_nettype wire

// ==== logic/p1gpio_pad.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_pad #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] fsel,
  input  wire logic [N-1:0] dir,
  input  wire logic [N-1:0] data,
  input  wire logic [N-1:0] pull,
  input  wire logic [N-1:0] alt_val,
  output var  logic [N-1:0] out_val,
  output var  logic [N-1:0] out_en,
  output var  logic [N-1:0] pu_en
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pin
      wire alt_out = fsel[i] & p1gpio_pkg::ALT_OUT_MSK[i];
      wire gpio    = ~fsel[i];
      wire pinless = p1gpio_pkg::EMPTY_MSK[i];
      // alternate output wins regardless of direction
      assign out_en[i]  = ~pinless & (alt_out | (gpio & dir[i]));
      assign out_val[i] = alt_out ? alt_val[i] : data[i];
      // pull-up only when acting as an input
      // a set direction bit kills the pull-up even on an alternate input
      assign pu_en[i]   = ~pinless & pull[i] & ~dir[i] & ~out_en[i];
    end
  endgenerate
endmodule : p1gpio_pad
`default_nettype wire

// ==== logic/p1gpio_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_top #(
  parameter int NPIN = p1gpio_pkg::NPIN
) (
  input  wire logic            MCLK,
  input  wire logic            RST,
  input  wire logic [3:0]      AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [31:0]     AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output var  logic [31:0]     AVS_READDATA,
  output var  logic            AVS_WAITREQUEST,
  input  wire logic [NPIN-1:0] PIN_IN,
  output var  logic [NPIN-1:0] PIN_OUT,
  output var  logic [NPIN-1:0] PIN_OE,
  output var  logic [NPIN-1:0] PIN_PULLUP,
  input  wire logic            PWM_OUT_SRC,
  input  wire logic            RTC_CLOCK_OUT_SRC,
  output var  logic            EXT_INT_3,
  output var  logic            EXT_INT_2,
  output var  logic            EXT_INT_1,
  output var  logic            EXT_INT_0,
  output var  logic            TIMER_V_TRIGGER_IN,
  output var  logic            TIMER_B1_EVENT_IN,
  output var  logic            SERIAL2_TX_SELECT,
  output var  logic            SERIAL1_TX_SELECT
);
  typedef enum logic [2:0]
  {
    P1G_IDLE = 3'b001,
    P1G_ACK  = 3'b010,
    P1G_HOLD = 3'b100
  } p1g_state_t;

  p1g_state_t state_ff;
  p1g_state_t nxt_state;

  logic [NPIN-1:0] fsel_ff;
  logic [NPIN-1:0] dir_ff;
  logic [NPIN-1:0] data_ff;
  logic [NPIN-1:0] pull_ff;
  logic [NPIN-1:0] nxt_fsel;
  logic [NPIN-1:0] nxt_dir;
  logic [NPIN-1:0] nxt_data;
  logic [NPIN-1:0] nxt_pull;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pad_val;
  logic [NPIN-1:0] pad_en;
  logic [NPIN-1:0] pad_pu;
  logic [NPIN-1:0] alt_val;
  logic [31:0]     nxt_rdata;
  logic [31:0]     rdata_ff;
  logic            wait_ff;
  p1gpio_pkg::p1g_req_t    req;
  p1gpio_pkg::p1g_alt_in_t nxt_alt;
  p1gpio_pkg::p1g_alt_in_t alt_ff;

  assign req.read      = AVS_READ;
  assign req.write     = AVS_WRITE;
  assign req.address   = AVS_ADDRESS;
  assign req.writedata = AVS_WRITEDATA[7:0];

  // request taken in idle; answer the next cycle, then one cycle of
  // recovery so a held request is not taken twice
  wire req_any  = req.read | req.write;
  wire take     = (state_ff == P1G_IDLE) & req_any;
  wire do_write = take & req.write & AVS_BYTEENABLE[0];
  wire hit_fsel = req.address == p1gpio_pkg::OFS_FSEL;
  wire hit_dir  = req.address == p1gpio_pkg::OFS_DIR;
  wire hit_data = req.address == p1gpio_pkg::OFS_DATA;
  wire hit_pull = req.address == p1gpio_pkg::OFS_PULL;

  always_comb
  begin
    case (state_ff)
      P1G_IDLE: nxt_state = req_any ? P1G_ACK : P1G_IDLE;
      P1G_ACK:  nxt_state = P1G_HOLD;
      P1G_HOLD: nxt_state = P1G_IDLE;
      default:  nxt_state = P1G_IDLE;
    endcase
  end

  // bit 3 of data and pull-up is held at one and cannot be written
  wire [NPIN-1:0] wmask = ~p1gpio_pkg::EMPTY_MSK[NPIN-1:0];
  wire [NPIN-1:0] wd    = req.writedata[NPIN-1:0];

  assign nxt_fsel = (do_write & hit_fsel) ? wd : fsel_ff;
  assign nxt_dir  = (do_write & hit_dir)  ? wd : dir_ff;
  assign nxt_data = (do_write & hit_data) ?
                    ((wd & wmask) | p1gpio_pkg::EMPTY_MSK[NPIN-1:0]) :
                    data_ff;
  assign nxt_pull = (do_write & hit_pull) ?
                    ((wd & wmask) | p1gpio_pkg::EMPTY_MSK[NPIN-1:0]) :
                    pull_ff;

  // data read mixes latch and live pin level per direction bit
  wire [NPIN-1:0] data_rd = ((data_ff & dir_ff) | (pin_sync & ~dir_ff)
                            & wmask) | p1gpio_pkg::EMPTY_MSK[NPIN-1:0];

  // direction reads as zero: it is write-only; unmapped reads zero
  wire [NPIN-1:0] rd_sel = hit_fsel ? fsel_ff :
                           hit_data ? data_rd :
                           hit_pull ? pull_ff : '0;

  assign nxt_rdata = (take & req.read) ? {{(32-NPIN){1'b0}}, rd_sel}
                                      : rdata_ff;

  // alternate inputs follow the synced pin whenever selected
  assign nxt_alt.ext_int_3 = fsel_ff[p1gpio_pkg::SEL_INT3] &
                             pin_sync[p1gpio_pkg::SEL_INT3];
  assign nxt_alt.timer_v_trigger_in = fsel_ff[p1gpio_pkg::SEL_INT3] &
                             pin_sync[p1gpio_pkg::SEL_INT3];
  assign nxt_alt.ext_int_2 = fsel_ff[p1gpio_pkg::SEL_INT2] &
                             pin_sync[p1gpio_pkg::SEL_INT2];
  assign nxt_alt.ext_int_1 = fsel_ff[p1gpio_pkg::SEL_INT1] &
                             pin_sync[p1gpio_pkg::SEL_INT1];
  assign nxt_alt.timer_b1_event_in = fsel_ff[p1gpio_pkg::SEL_INT1] &
                             pin_sync[p1gpio_pkg::SEL_INT1];
  assign nxt_alt.ext_int_0 = fsel_ff[p1gpio_pkg::SEL_INT0] &
                             pin_sync[p1gpio_pkg::SEL_INT0];

  // pin 1 carries PWM, pin 0 the clock output
  always_comb
  begin
    alt_val = '0;
    alt_val[p1gpio_pkg::PIN_PWM] = PWM_OUT_SRC;
    alt_val[p1gpio_pkg::PIN_RTC] = RTC_CLOCK_OUT_SRC;
  end

  p1gpio_sync #(
    .W (NPIN)
  ) u_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (PIN_IN),
    .q   (pin_sync)
  );

  // pad select bits for pins 1 to 3 differ from positions: pin 1 uses
  // select 2, pins 2 and 3 have none, so select is remapped before the pads
  wire [NPIN-1:0] pad_fsel =
    (fsel_ff & p1gpio_pkg::ALT_IN_MSK[NPIN-1:0]) |
    (NPIN'(fsel_ff[p1gpio_pkg::SEL_PWM]) << p1gpio_pkg::PIN_PWM) |
    (NPIN'(fsel_ff[p1gpio_pkg::SEL_RTC]) << p1gpio_pkg::PIN_RTC);

  p1gpio_pad #(
    .N (NPIN)
  ) u_pad (
    .fsel    (pad_fsel),
    .dir     (dir_ff),
    .data    (data_ff),
    .pull    (pull_ff),
    .alt_val (alt_val),
    .out_val (pad_val),
    .out_en  (pad_en),
    .pu_en   (pad_pu)
  );

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_ff <= P1G_IDLE;
      fsel_ff  <= p1gpio_pkg::FSEL_RST;
      dir_ff   <= p1gpio_pkg::DIR_RST;
      data_ff  <= p1gpio_pkg::DATA_RST;
      pull_ff  <= p1gpio_pkg::PULL_RST;
      rdata_ff <= '0;
      wait_ff  <= 1'b1;
      alt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      fsel_ff  <= nxt_fsel;
      dir_ff   <= nxt_dir;
      data_ff  <= nxt_data;
      pull_ff  <= nxt_pull;
      rdata_ff <= nxt_rdata;
      wait_ff  <= ~(nxt_state == P1G_ACK);
      alt_ff   <= nxt_alt;
    end
  end

  // pad outputs registered so every top output comes from a flop
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PIN_OUT    <= '0;
      PIN_OE     <= '0;
      PIN_PULLUP <= '0;
      SERIAL2_TX_SELECT <= 1'b0;
      SERIAL1_TX_SELECT <= 1'b0;
    end
    else
    begin
      PIN_OUT    <= pad_val;
      PIN_OE     <= pad_en;
      PIN_PULLUP <= pad_pu;
      SERIAL2_TX_SELECT <= fsel_ff[p1gpio_pkg::SEL_TX2];
      SERIAL1_TX_SELECT <= fsel_ff[p1gpio_pkg::SEL_TX1];
    end
  end

  assign AVS_READDATA       = rdata_ff;
  assign AVS_WAITREQUEST    = wait_ff;
  assign EXT_INT_3          = alt_ff.ext_int_3;
  assign EXT_INT_2          = alt_ff.ext_int_2;
  assign EXT_INT_1          = alt_ff.ext_int_1;
  assign EXT_INT_0          = alt_ff.ext_int_0;
  assign TIMER_V_TRIGGER_IN = alt_ff.timer_v_trigger_in;
  assign TIMER_B1_EVENT_IN  = alt_ff.timer_b1_event_in;
endmodule : p1gpio_top
`default_nettype wire

// ==== verif/p1gpio_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_assertions #(
  parameter int NPIN = 8
) (
  input wire logic            MCLK,
  input wire logic            RST,
  input wire logic [3:0]      AVS_ADDRESS,
  input wire logic            AVS_READ,
  input wire logic [31:0]     AVS_READDATA,
  input wire logic            AVS_WAITREQUEST,
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PIN_PULLUP,
  input wire logic            EXT_INT_3,
  input wire logic            EXT_INT_2,
  input wire logic            EXT_INT_1,
  input wire logic            EXT_INT_0,
  input wire logic            TIMER_V_TRIGGER_IN,
  input wire logic            TIMER_B1_EVENT_IN
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire [3:0] ints = {EXT_INT_3, EXT_INT_2, EXT_INT_1, EXT_INT_0};

  chk_reset_quiet: assert property (
    disable iff (1'h0) RST |=> !PIN_OE && AVS_WAITREQUEST)
    else $error("outputs active after reset");
  chk_empty_bit: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h8 |-> AVS_READDATA[3])
    else $error("empty data bit read as zero");
  chk_pull_drive: assert property (!(PIN_PULLUP & PIN_OE))
    else $error("pull-up on a driven pin");
  chk_alt_undriven: assert property (!(ints & PIN_OE[7:4]))
    else $error("alternate input pin driven");
  chk_timer_v_trigger_in_pair: assert property (EXT_INT_3 == TIMER_V_TRIGGER_IN)
    else $error("timer v trigger differs from int 3");
  chk_tmib_pair: assert property (EXT_INT_1 == TIMER_B1_EVENT_IN)
    else $error("timer b1 event differs from int 1");
  // the interrupt path is two sync flops plus the output register
  chk_int3_delay: assert property (EXT_INT_3 |-> $past(PIN_IN[7], 3))
    else $error("int 3 high without pin 7 high");
  chk_int2_delay: assert property (EXT_INT_2 |-> $past(PIN_IN[6], 3))
    else $error("int 2 high without pin 6 high");
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property ($rose(EXT_INT_3));
  cover property ($rose(PIN_OE[0]));
endmodule : p1gpio_assertions

bind p1gpio_top p1gpio_assertions #(.NPIN(NPIN)) i_chk (.MCLK, .RST,
  .AVS_ADDRESS, .AVS_READ, .AVS_READDATA, .AVS_WAITREQUEST, .PIN_IN, .PIN_OE,
  .PIN_PULLUP, .EXT_INT_3, .EXT_INT_2, .EXT_INT_1, .EXT_INT_0,
  .TIMER_V_TRIGGER_IN, .TIMER_B1_EVENT_IN);
`default_nettype wire

// ==== verif/p1gpio_board.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_board (
  input  wire logic [7:0] PIN_OUT,
  input  wire logic [7:0] PIN_OE,
  input  wire logic [7:0] PIN_PULLUP,
  input  wire logic [7:0] ext,
  output var  logic [7:0] PIN_IN
);
  // an undriven, unpulled pin shows whatever the board puts on it
  always_comb
    for (int i = 0; i < 8; i++)
      PIN_IN[i] = PIN_OE[i] ? PIN_OUT[i] : (PIN_PULLUP[i] | ext[i]);
endmodule : p1gpio_board
`default_nettype wire

// ==== verif/p1gpio_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module p1gpio_top_tb;
  logic        MCLK = 1'h0;
  logic        RST = 1'h1;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'h0;
  logic        AVS_WRITE = 1'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
  logic        PWM_OUT_SRC = 1'h0;
  logic        RTC_CLOCK_OUT_SRC = 1'h0;
  logic        EXT_INT_3, EXT_INT_2, EXT_INT_1, EXT_INT_0;
  logic        TIMER_V_TRIGGER_IN, TIMER_B1_EVENT_IN;
  logic        SERIAL2_TX_SELECT, SERIAL1_TX_SELECT;
  logic [7:0]  ext = 8'h00;
  logic [7:0]  m_fsel, m_dir, m_data, m_pull, e_oe, e_out, e_pu, e_pin;
  logic [31:0] rd;
  int          errors = 0;
  int          checks_done = 0;
  int          seed = 38125;

  always #20 MCLK = ~MCLK;

  p1gpio_top i_dut (.MCLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .PIN_IN,
    .PIN_OUT, .PIN_OE, .PIN_PULLUP, .PWM_OUT_SRC, .RTC_CLOCK_OUT_SRC,
    .EXT_INT_3, .EXT_INT_2, .EXT_INT_1, .EXT_INT_0, .TIMER_V_TRIGGER_IN,
    .TIMER_B1_EVENT_IN, .SERIAL2_TX_SELECT, .SERIAL1_TX_SELECT);
  p1gpio_board i_board (.PIN_OUT, .PIN_OE, .PIN_PULLUP, .ext, .PIN_IN);

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int n = 0;
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'h0 && n < 20);
    if (AVS_WAITREQUEST !== 1'h0)
    begin
      errors++;
      print_verdict;
    end
    else
    begin
      rd = AVS_READDATA;
      AVS_READ <= 1'h0;
      AVS_WRITE <= 1'h0;
      // recovery cycle before the next request may be taken
      @(posedge MCLK);
    end
  endtask : bus

  task automatic wreg(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    bus(1'h1, a, d, be);
    if (be[0])
      case (a)
        4'h0: m_fsel = d;
        4'h4: m_dir = d;
        4'h8: m_data = d & 8'hf7;
        4'hc: m_pull = d & 8'hf7;
        default: ;
      endcase
  endtask : wreg

  task automatic check_all;
    // covers output register, pin loop back and both sync flops
    repeat (6) @(posedge MCLK);
    e_oe = m_dir & ~(m_fsel & 8'hf0) & 8'hf7 | {6'h00, m_fsel[2], m_fsel[0]};
    e_out = {m_data[7:2], m_fsel[2] ? PWM_OUT_SRC : m_data[1],
             m_fsel[0] ? RTC_CLOCK_OUT_SRC : m_data[0]};
    e_pu = m_pull & ~m_dir & ~e_oe & 8'hf7;
    e_pin = e_oe & e_out | ~e_oe & (e_pu | ext);
    chk("oe", e_oe, PIN_OE);
    chk("out", e_out & e_oe, PIN_OUT & PIN_OE);
    chk("pullup", e_pu, PIN_PULLUP);
    chk("alt", {m_fsel[7:4] & e_pin[7:4], m_fsel[7] & e_pin[7],
      m_fsel[5] & e_pin[5], m_fsel[3], m_fsel[1]}, {EXT_INT_3, EXT_INT_2,
      EXT_INT_1, EXT_INT_0, TIMER_V_TRIGGER_IN, TIMER_B1_EVENT_IN,
      SERIAL2_TX_SELECT, SERIAL1_TX_SELECT});
    bus(1'h0, 4'h0, 8'h00, 4'hf);
    chk("fsel", m_fsel, rd[7:0]);
    chk("upper", 8'h00, rd[31:24] | rd[23:16] | rd[15:8]);
    bus(1'h0, 4'h8, 8'h00, 4'hf);
    chk("data", m_dir & m_data | ~m_dir & e_pin | 8'h08, rd[7:0]);
    bus(1'h0, 4'hc, 8'h00, 4'hf);
    chk("pull", m_pull | 8'h08, rd[7:0]);
    bus(1'h0, 4'h2, 8'h00, 4'hf);
    chk("unmapped", 8'h00, rd[7:0]);
  endtask : check_all

  initial
  begin
    m_fsel = 8'h00;
    m_dir = 8'h00;
    m_data = 8'h00;
    m_pull = 8'h00;
    repeat (10) @(posedge MCLK);
    RST <= 1'h0;
    @(posedge MCLK);
    check_all;
    $display("test reset done");
    for (int k = 0; k < 40; k++)
    begin
      ext <= 8'($random(seed));
      PWM_OUT_SRC <= 1'($random(seed));
      RTC_CLOCK_OUT_SRC <= 1'($random(seed));
      wreg(4'h0, 8'($random(seed)), 4'($random(seed)));
      wreg(4'h4, 8'($random(seed)), 4'($random(seed)));
      wreg(4'h8, 8'($random(seed)), 4'($random(seed)));
      wreg(4'hc, 8'($random(seed)), 4'($random(seed)));
      wreg(4'h2, 8'($random(seed)), 4'hf);
      check_all;
    end
    $display("test random done");
    RST <= 1'h1;
    repeat (2) @(posedge MCLK);
    RST <= 1'h0;
    m_fsel = 8'h00;
    m_dir = 8'h00;
    m_data = 8'h00;
    m_pull = 8'h00;
    @(posedge MCLK);
    check_all;
    $display("test second reset done");
    print_verdict;
  end
endmodule : p1gpio_top_tb
`default_nettype wire
